// ### design/smbus_slave.v
/*
 * smbus slave front end: address decode with strapped low bits,
 * register pointer, one or two byte writes, one byte reads, and the
 * alert response address answer that releases the alert output.
 * assumes scl and sda come from the bus through pull-ups, and that
 * register contents sit outside behind the reg_* ports.
 */
// Notes on behaviour
// R1: answer address 01011 plus two strap bits
// R2: gnd 00, vcc 01, open 10 strap mapping
// R3: strap caught once after reset release only
// R4: host opens every transfer with start
// R5: shift seven address bits then direction bit
// R6: acknowledge own address on ninth clock
// R7: nine clocks per byte, sda moves low
// R8: host ends write with stop
// R9: host ends read with nack then stop
// R10: direction fixed until next start
// R11: writes one or two bytes, reads one
// R12: first write byte loads the pointer
// R13: second write byte goes to pointed register
// R14: read returns register chosen by pointer
// R15: smbus read byte transaction supported
// R16: answer alert response address with own address
// R17: alert response address never a device address
// R18: lose arbitration on ara, back off
// R19: release alert after answering alert response
// R20: alert output is active low open drain
// R21: ignore other addresses, ara only while alerting
// R22: pointer kept between bus operations
`timescale 1ns/1ps
`include "smbus_slave_map.vh"

module smbus_slave (
   // clock and reset
   input wire CORE_CLK_I,
   input wire RST_N_I,
   // bus pins
   input wire SCL_I,
   input wire SDA_I,
   output reg SDA_O,
   output reg SDA_OE_N_O,
   // strap pin, seen as pulled-high and pulled-low samples
   input wire STRAP_HI_I,
   input wire STRAP_LO_I,
   // alert source and open-drain alert pin
   input wire ALERT_REQ_I,
   output reg ALERT_N_O,
   output reg ALERT_OE_N_O,
   // register file access
   output reg [7:0] REG_PTR_O,
   output reg [7:0] REG_WDATA_O,
   output reg REG_WE_O,
   input wire [7:0] REG_RDATA_I
);

   localparam S_IDLE = 5'h01;
   localparam S_ADDR = 5'h02;
   localparam S_WR = 5'h04;
   localparam S_RD = 5'h08;
   localparam S_WAIT = 5'h10;

   reg [1:0] rst_q;
   wire rst_n = rst_q[1];
   reg [2:0] scl_q, sda_q;
   reg [1:0] shi_q, slo_q, areq_q;
   reg [4:0] state_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg ack_q, ara_q;
   reg alert_done_q;
   reg [1:0] wcnt_q;
   reg [1:0] strap_q;
   reg strap_done_q;
   reg [3:0] wait_q;
   wire [6:0] own_addr = {`DEV_ADDR_HI, strap_q};

   // reset release through two flops
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end

   // pin synchronisers; third stage only for edge finding
   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
         shi_q <= 2'h0;
         slo_q <= 2'h0;
         areq_q <= 2'h0;
      end else begin
         scl_q <= {scl_q[1:0], SCL_I};
         sda_q <= {sda_q[1:0], SDA_I};
         shi_q <= {shi_q[0], STRAP_HI_I};
         slo_q <= {slo_q[0], STRAP_LO_I};
         areq_q <= {areq_q[0], ALERT_REQ_I};
      end
   end

   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire start_c = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2]; // [R4]
   wire stop_c = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];  // [R8] [R9]
   wire sda_in = sda_q[1];

   // strap caught once, a few cycles after release
   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         strap_q <= `STRAP_LO_GND;
         strap_done_q <= 1'b0;
         wait_q <= 4'h0;
      end else if (!strap_done_q) begin // [R3]
         wait_q <= wait_q + 4'h1;
         if (wait_q == `STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            // pulled-up sample high and pulled-down sample low: pin is open
            if (shi_q[1] & ~slo_q[1])
               strap_q <= `STRAP_LO_OPEN; // [R2]
            else if (slo_q[1])
               strap_q <= `STRAP_LO_VCC;
            else
               strap_q <= `STRAP_LO_GND;
         end
      end
   end

   // byte engine
   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         ara_q <= 1'b0;
         alert_done_q <= 1'b0;
         wcnt_q <= 2'h0;
         SDA_O <= 1'b0;
         SDA_OE_N_O <= 1'b1;
         REG_PTR_O <= `PTR_RST;
         REG_WDATA_O <= 8'h00;
         REG_WE_O <= 1'b0;
         ALERT_N_O <= 1'b0;
         ALERT_OE_N_O <= 1'b1;
      end else begin
         REG_WE_O <= 1'b0;
         // alert pin follows the source until answered; a dropped source re-arms it
         if (!areq_q[1]) begin
            ALERT_OE_N_O <= 1'b1;
            alert_done_q <= 1'b0;
         end else if (!alert_done_q)
            ALERT_OE_N_O <= 1'b0; // [R20]
         if (start_c) begin
            state_q <= S_ADDR; // [R10]
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            ara_q <= 1'b0;
            SDA_OE_N_O <= 1'b1;
         end else if (stop_c) begin
            state_q <= S_IDLE;
            SDA_OE_N_O <= 1'b1;
         end else begin
            case (state_q)
               S_IDLE: begin
                  SDA_OE_N_O <= 1'b1;
               end
               S_ADDR, S_WR: begin
                  if (scl_rise && !ack_q) begin
                     sh_q <= {sh_q[6:0], sda_in}; // [R5]
                     bit_q <= bit_q + 4'h1;
                  end
                  if (scl_fall && ack_q) begin
                     // ninth clock over
                     ack_q <= 1'b0;
                     bit_q <= 4'h0;
                     SDA_OE_N_O <= 1'b1;
                     if (state_q == S_ADDR && sh_q[0]) begin
                        state_q <= S_RD;
                        sh_q <= ara_q ? {own_addr, 1'b0} : REG_RDATA_I; // [R14] [R15] [R16]
                        SDA_OE_N_O <= ara_q ? own_addr[6] : REG_RDATA_I[7];
                        bit_q <= 4'h1;
                     end else if (state_q == S_ADDR)
                        state_q <= S_WR;
                  end else if (scl_fall && bit_q == `BYTE_BITS) begin
                     if (state_q == S_ADDR) begin
                        if (sh_q[7:1] == own_addr) begin // [R1] [R21]
                           ack_q <= 1'b1;
                           SDA_OE_N_O <= 1'b0; // [R6]
                           wcnt_q <= 2'h0;
                        end else if (sh_q[7:1] == `ALERT_RESP_ADDR && sh_q[0] && !ALERT_OE_N_O) begin
                           ack_q <= 1'b1;
                           ara_q <= 1'b1;
                           SDA_OE_N_O <= 1'b0; // [R21]
                        end else
                           state_q <= S_WAIT;
                     end else begin
                        if (wcnt_q == 2'h0)
                           REG_PTR_O <= sh_q; // [R12] [R22]
                        else if (wcnt_q == 2'h1) begin
                           REG_WDATA_O <= sh_q; // [R13]
                           REG_WE_O <= 1'b1;
                        end
                        if (wcnt_q != 2'h2) begin
                           wcnt_q <= wcnt_q + 2'h1;
                           ack_q <= 1'b1;
                           SDA_OE_N_O <= 1'b0; // [R11]
                        end else
                           state_q <= S_WAIT;
                     end
                  end
               end
               S_RD: begin
                  if (scl_rise) begin
                     // lost arbitration: bus low while we released
                     if (bit_q != `BYTE_BITS + 4'h1 && SDA_OE_N_O && !sda_in) begin
                        state_q <= S_WAIT; // [R18]
                        SDA_OE_N_O <= 1'b1;
                     end
                  end
                  if (scl_fall) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q < `BYTE_BITS) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        SDA_OE_N_O <= sh_q[6];
                     end else begin
                        // one byte only, then release for nack
                        SDA_OE_N_O <= 1'b1; // [R11]
                        if (bit_q == `BYTE_BITS + 4'h1) begin
                           state_q <= S_WAIT;
                           // answered: alert stays off until its source drops (set wins)
                           if (ara_q) begin
                              ALERT_OE_N_O <= 1'b1; // [R19]
                              alert_done_q <= 1'b1;
                           end
                        end
                     end
                  end
               end
               S_WAIT: begin
                  SDA_OE_N_O <= 1'b1;
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// ### design/smbus_slave_map.vh
/*
 * constants for the smbus slave front end: address fields, strap codes,
 * bit counts and reset values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SMBUS_SLAVE_MAP_VH
`define SMBUS_SLAVE_MAP_VH

// fixed upper five address bits
`define DEV_ADDR_HI 5'h0b
// alert response address, seven bits
`define ALERT_RESP_ADDR 7'h0c
// strap pin codes as decoded from the pin inputs
`define STRAP_LO_GND 2'h0
`define STRAP_LO_VCC 2'h1
`define STRAP_LO_OPEN 2'h2
// bits in a byte before the acknowledge slot
`define BYTE_BITS 4'h8
// pointer reset value
`define PTR_RST 8'h00
// cycles after reset release before the strap is caught
`define STRAP_WAIT 4'h4

`endif

// ### bench/smbus_slave_chk_assertions.sv
/* concurrent checks on the smbus slave ports: pin timing, write strobe, alert.
   assumes binding to every smbus_slave instance and a bus idling high. */
`timescale 1ns/1ps
module smbus_slave_chk (
   // clock and reset
   input wire CORE_CLK_I,
   input wire RST_N_I,
   // bus and alert pins
   input wire SCL_I,
   input wire SDA_O,
   input wire SDA_OE_N_O,
   input wire ALERT_REQ_I,
   input wire ALERT_N_O,
   input wire ALERT_OE_N_O,
   // register side
   input wire [7:0] REG_PTR_O,
   input wire REG_WE_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // pin and strobe relations
   sda_moves_low_a: assert property ($changed(SDA_OE_N_O) |-> !SCL_I) else $error("sda moved, scl high");
   reset_idle_a: assert property ($rose(RST_N_I) |-> SDA_OE_N_O && ALERT_OE_N_O && REG_PTR_O == 8'h00)
      else $error("outputs not idle at reset");
   alert_rise_a: assert property ($rose(ALERT_REQ_I) |-> ##[0:6] !ALERT_OE_N_O) else $error("alert not raised");
   alert_drop_a: assert property ($fell(ALERT_REQ_I) |-> ##[0:6] ALERT_OE_N_O) else $error("alert not dropped");
   we_pulse_a: assert property (REG_WE_O |=> !REG_WE_O) else $error("write strobe too long");
   we_steady_a: assert property (REG_WE_O |-> !SCL_I && $stable(REG_PTR_O)) else $error("write strobe misplaced");
   we_acked_a: assert property (REG_WE_O |-> ##[0:3] !SDA_OE_N_O) else $error("write without ack");
   od_levels_a: assert property (!SDA_O && !ALERT_N_O) else $error("open drain level not low");
endmodule
bind smbus_slave smbus_slave_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I),
   .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .ALERT_REQ_I(ALERT_REQ_I), .ALERT_N_O(ALERT_N_O),
   .ALERT_OE_N_O(ALERT_OE_N_O), .REG_PTR_O(REG_PTR_O), .REG_WE_O(REG_WE_O));

// ### bench/smbus_host.sv
/* smbus host model: start, byte transfer and stop on an open-drain sda.
   assumes a 4 ns core clock; scl runs at 48 ns only inside frames. */
`timescale 1ns/1ps
module smbus_host (
   input wire clk_i,
   input wire dev_oe_n_i,
   output reg scl_o,
   output wire sda_o
);
   reg sda_q = 1'b1;
   initial scl_o = 1'b1;
   // wired-and with pull-up, released line reads high
   assign sda_o = sda_q & dev_oe_n_i;
   task wt(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   // sda falls while scl high, also as repeated start
   task start;
      begin
         sda_q <= 1'b1;
         wt(6);
         scl_o <= 1'b1;
         wt(6);
         sda_q <= 1'b0;
         wt(6);
         scl_o <= 1'b0;
         wt(1);
      end
   endtask
   // eight bits msb first, then a released ack slot (nack on reads)
   task xbyte(input [7:0] tx, output [7:0] rx, output ack);
      integer k;
      begin
         for (k = 8; k >= 0; k = k - 1) begin
            sda_q <= (k == 0) ? 1'b1 : tx[k-1];
            wt(5);
            scl_o <= 1'b1;
            wt(6);
            if (k == 0) ack = sda_o;
            else rx[k-1] = sda_o;
            scl_o <= 1'b0;
            wt(1);
         end
      end
   endtask
   // sda low then high during the closing clock
   task stop;
      begin
         sda_q <= 1'b0;
         wt(6);
         scl_o <= 1'b1;
         wt(6);
         sda_q <= 1'b1;
         wt(6);
      end
   endtask
endmodule

// ### bench/testbench.sv
/* self-checking bench for the smbus slave: straps, pointer, writes, reads, alert answer.
   assumes the host model drives scl and the pulled-up sda. */
`timescale 1ns/1ps
module testbench;
   reg CORE_CLK_I = 1'b0;
   reg RST_N_I = 1'b0;
   reg STRAP_HI_I = 1'b0;
   reg STRAP_LO_I = 1'b0;
   reg ALERT_REQ_I = 1'b0;
   reg [7:0] regs [0:255];
   reg [7:0] shadow [0:255];
   reg [31:0] seed = 32'h01e27afb;
   reg [6:0] own;
   reg [7:0] rd;
   reg [7:0] p;
   reg [7:0] d;
   reg a;
   integer err_total = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer i;
   wire SCL_I, SDA_I, SDA_O, SDA_OE_N_O, ALERT_N_O, ALERT_OE_N_O, REG_WE_O;
   wire [7:0] REG_PTR_O, REG_WDATA_O;
   always #2 CORE_CLK_I = ~CORE_CLK_I;
   smbus_slave u_smbus_slave (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
      .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .STRAP_HI_I(STRAP_HI_I), .STRAP_LO_I(STRAP_LO_I),
      .ALERT_REQ_I(ALERT_REQ_I), .ALERT_N_O(ALERT_N_O), .ALERT_OE_N_O(ALERT_OE_N_O), .REG_PTR_O(REG_PTR_O),
      .REG_WDATA_O(REG_WDATA_O), .REG_WE_O(REG_WE_O), .REG_RDATA_I(regs[REG_PTR_O]));
   smbus_host u_smbus_host (.clk_i(CORE_CLK_I), .dev_oe_n_i(SDA_OE_N_O), .scl_o(SCL_I), .sda_o(SDA_I));
   // register file behind the pointer, plus hang guard
   always @(posedge CORE_CLK_I) begin
      if (REG_WE_O) regs[REG_PTR_O] <= REG_WDATA_O;
      cyc = cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         results;
      end
   end
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   // power-up with a strap code, then disturb the strap
   task powerup(input hi, input lo);
      begin
         @(posedge CORE_CLK_I);
         RST_N_I <= 1'b0;
         STRAP_HI_I <= hi;
         STRAP_LO_I <= lo;
         repeat (12) @(posedge CORE_CLK_I);
         RST_N_I <= 1'b1;
         repeat (20) @(posedge CORE_CLK_I);
         own = {5'h0b, hi & ~lo, lo};
         STRAP_HI_I <= 1'b1;
         STRAP_LO_I <= ~lo;
      end
   endtask
   // address byte with ack check, then one read byte and stop
   task rdreg(input [6:0] ad, input [7:0] exp);
      begin
         u_smbus_host.start;
         u_smbus_host.xbyte({ad, 1'b1}, rd, a);
         chk({7'h00, a}, 8'h00);
         u_smbus_host.xbyte(8'hff, rd, a);
         u_smbus_host.stop;
         chk(rd, exp);
      end
   endtask
   task results;
      begin
         $display("compares %0d, mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      // preload distinct contents so unwritten reads are not trivially zero
      for (i = 0; i < 256; i = i + 1) begin
         regs[i] = i[7:0] ^ 8'h5a;
         shadow[i] = i[7:0] ^ 8'h5a;
      end
      // gnd, open, vcc straps; own address acked, neighbour ignored
      for (i = 0; i < 3; i = i + 1) begin
         powerup(i != 0, i == 2);
         u_smbus_host.start;
         u_smbus_host.xbyte({own, 1'b0}, rd, a);
         chk({7'h00, a}, 8'h00);
         u_smbus_host.start;
         u_smbus_host.xbyte({own ^ 7'h03, 1'b0}, rd, a);
         u_smbus_host.stop;
         chk({7'h00, a}, 8'h01);
      end
      $display("strap test done");
      // random pointer and data, third byte refused, reads repeated
      for (i = 0; i < 8; i = i + 1) begin
         seed = lfsr(seed);
         p = (i == 0) ? 8'hff : seed[7:0];
         d = seed[15:8];
         u_smbus_host.start;
         u_smbus_host.xbyte({own, 1'b0}, rd, a);
         u_smbus_host.xbyte(p, rd, a);
         chk(REG_PTR_O, p);
         u_smbus_host.xbyte(d, rd, a);
         chk(regs[p], d);
         chk({7'h00, a}, 8'h00);
         shadow[p] = d;
         u_smbus_host.xbyte(~d, rd, a);
         u_smbus_host.stop;
         chk({7'h00, a}, 8'h01);
         rdreg(own, d);
         rdreg(own, d);
         // pointer write then repeated start into a read
         u_smbus_host.start;
         u_smbus_host.xbyte({own, 1'b0}, rd, a);
         u_smbus_host.xbyte(~p, rd, a);
         rdreg(own, shadow[~p]);
      end
      $display("data test done");
      // alert answer with own address, release, re-raise, refusal when quiet
      ALERT_REQ_I <= 1'b1;
      repeat (8) @(posedge CORE_CLK_I);
      chk({7'h00, ALERT_OE_N_O}, 8'h00);
      // a lower address wins the alert answer: back off, keep alerting
      u_smbus_host.start;
      u_smbus_host.xbyte({7'h0c, 1'b1}, rd, a);
      chk({7'h00, a}, 8'h00);
      u_smbus_host.xbyte(8'h00, rd, a);
      u_smbus_host.stop;
      chk(rd, 8'h00);
      chk({7'h00, ALERT_OE_N_O}, 8'h00);
      rdreg(7'h0c, {own, 1'b0});
      chk({7'h00, ALERT_OE_N_O}, 8'h01);
      ALERT_REQ_I <= 1'b0;
      repeat (8) @(posedge CORE_CLK_I);
      ALERT_REQ_I <= 1'b1;
      repeat (8) @(posedge CORE_CLK_I);
      chk({7'h00, ALERT_OE_N_O}, 8'h00);
      ALERT_REQ_I <= 1'b0;
      repeat (8) @(posedge CORE_CLK_I);
      u_smbus_host.start;
      u_smbus_host.xbyte({7'h0c, 1'b1}, rd, a);
      u_smbus_host.stop;
      chk({7'h00, a}, 8'h01);
      $display("alert test done");
      results;
   end
endmodule
